/* logic/pcio_defines.svh */
// Pin counts, the fixed rest pin, default map values and timing counts of the press-cycle I/O sequencer
`ifndef PCIO_DEFINES_SVH
`define PCIO_DEFINES_SVH

// ==========================================================
// Pin counts
`define PCIO_NUM_IN 15
`define PCIO_NUM_OUT 15
`define PCIO_SEL_W 5
`define PCIO_REST_PIN 4'h1

// ==========================================================
// Default input map (function codes, see package)
`define PCIO_DEF_IN0 5'h01
`define PCIO_DEF_IN1 5'h02
`define PCIO_DEF_IN2 5'h05
`define PCIO_DEF_IN3 5'h06
`define PCIO_DEF_IN4 5'h0b
`define PCIO_DEF_IN5 5'h0d
`define PCIO_DEF_IN6 5'h0e
`define PCIO_DEF_IN7 5'h0f

// ==========================================================
// Default output map
`define PCIO_DEF_OUT0 5'h01
`define PCIO_DEF_OUT1 5'h02
`define PCIO_DEF_OUT2 5'h04
`define PCIO_DEF_OUT3 5'h05
`define PCIO_DEF_OUT4 5'h07
`define PCIO_DEF_OUT7 5'h03

// ==========================================================
// Debounce timing
`define PCIO_CLK_HZ 25000000
`define PCIO_DEBOUNCE_US 1000
`define PCIO_DEBOUNCE_CYC ((`PCIO_DEBOUNCE_US * (`PCIO_CLK_HZ / 1000000)))

`endif

/* logic/pcio_pkg.sv */
// Types of the press-cycle I/O sequencer
package pcio_pkg;
	typedef logic [4:0] pcio_fn_t;

	// Input functions
	typedef enum logic [4:0] {
		PCIO_IN_NONE = 5'h00,
		PCIO_IN_START = 5'h01,
		PCIO_IN_REST = 5'h02,
		PCIO_IN_RECIPE_BIT = 5'h03,
		PCIO_IN_STEP_BIT = 5'h04,
		PCIO_IN_SCRAP1 = 5'h05,
		PCIO_IN_SCRAP2 = 5'h06,
		PCIO_IN_SAMPLE_BIN = 5'h07,
		PCIO_IN_RESET = 5'h08,
		PCIO_IN_AIR = 5'h09,
		PCIO_IN_PERMIT = 5'h0a,
		PCIO_IN_TEST_RET1 = 5'h0b,
		PCIO_IN_PICK = 5'h0c,
		PCIO_IN_SERVICE = 5'h0d,
		PCIO_IN_PULSE_L = 5'h0e,
		PCIO_IN_PULSE_R = 5'h0f,
		PCIO_IN_NO_ALARM = 5'h10,
		PCIO_IN_SAFETY = 5'h11,
		PCIO_IN_TABLE = 5'h12
	} pcio_in_fn_e;

	// Output functions
	typedef enum logic [4:0] {
		PCIO_OUT_NONE = 5'h00,
		PCIO_OUT_PASS = 5'h01,
		PCIO_OUT_FAIL1 = 5'h02,
		PCIO_OUT_FAIL2 = 5'h03,
		PCIO_OUT_CONSENT = 5'h04,
		PCIO_OUT_ALERT = 5'h05,
		PCIO_OUT_TEST_TRIG = 5'h06,
		PCIO_OUT_CONTACT = 5'h07,
		PCIO_OUT_RECIPE_BIT = 5'h08,
		PCIO_OUT_STEP_BIT = 5'h09,
		PCIO_OUT_LAMP_PASS = 5'h0a,
		PCIO_OUT_LAMP_FAIL1 = 5'h0b,
		PCIO_OUT_LAMP_FAIL2 = 5'h0c
	} pcio_out_fn_e;

	// Cycle states, Gray along idle->press->return->result
	typedef enum logic [2:0] {
		PCIO_ST_IDLE = 3'b000,
		PCIO_ST_PRESS = 3'b001,
		PCIO_ST_RETURN = 3'b011,
		PCIO_ST_RESULT = 3'b010,
		PCIO_ST_LOCK = 3'b110
	} pcio_state_e;
endpackage

/* logic/pcio_debounce.sv */
// Two-flop synchroniser and debounce filter for one input
`timescale 1ns/1ps
`include "pcio_defines.svh"
module pcio_debounce #(
	parameter int CYCLES = `PCIO_DEBOUNCE_CYC
) (
	// Clock and reset
	input wire logic clk,
	input wire logic arst_n,
	// Pin and filtered level
	input wire logic pin,
	output logic level
);
	localparam int CW = $clog2(CYCLES + 1);
	logic meta_q;
	logic sync_q;
	logic [CW-1:0] cnt_q;

	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			meta_q <= 1'b0;
			sync_q <= 1'b0;
		end else begin
			meta_q <= pin;
			sync_q <= meta_q;
		end
	end

	// Level changes only after it stays stable for CYCLES clocks
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			cnt_q <= '0;
			level <= 1'b0;
		end else if (sync_q == level) begin
			cnt_q <= '0;
		end else if (cnt_q == CW'(CYCLES - 1)) begin
			cnt_q <= '0;
			level <= sync_q;
		end else begin
			cnt_q <= cnt_q + 1'b1;
		end
	end
endmodule

/* logic/pcio_out_mux.sv */
// One output pin function selector
`timescale 1ns/1ps
`include "pcio_defines.svh"
module pcio_out_mux (
	// Clock and reset
	input wire logic clk,
	input wire logic arst_n,
	// Selection
	input wire pcio_pkg::pcio_fn_t fn,
	input wire logic [3:0] bit_idx,
	// Function sources
	input wire logic pass,
	input wire logic fail1,
	input wire logic fail2,
	input wire logic consent,
	input wire logic alert,
	input wire logic test_trig,
	input wire logic contact,
	input wire logic [7:0] recipe,
	input wire logic [7:0] step,
	// Pin
	output logic pin
);
	import pcio_pkg::*;
	logic pin_d;

	always_comb begin
		case (fn)
			PCIO_OUT_PASS, PCIO_OUT_LAMP_PASS: pin_d = pass;
			PCIO_OUT_FAIL1, PCIO_OUT_LAMP_FAIL1: pin_d = fail1;
			PCIO_OUT_FAIL2, PCIO_OUT_LAMP_FAIL2: pin_d = fail2;
			PCIO_OUT_CONSENT: pin_d = consent;
			PCIO_OUT_ALERT: pin_d = alert;
			PCIO_OUT_TEST_TRIG: pin_d = test_trig;
			PCIO_OUT_CONTACT: pin_d = contact;
			PCIO_OUT_RECIPE_BIT: pin_d = (bit_idx < 4'h8) ? recipe[bit_idx[2:0]] : 1'b0;
			PCIO_OUT_STEP_BIT: pin_d = (bit_idx < 4'h8) ? step[bit_idx[2:0]] : 1'b0;
			default: pin_d = 1'b0;
		endcase
	end

	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			pin <= 1'b0;
		end else begin
			pin <= pin_d;
		end
	end
endmodule

/* logic/pcio_sequencer.sv */
// Press-cycle I/O function mapper and cycle sequencer
`timescale 1ns/1ps
`include "pcio_defines.svh"

module pcio_sequencer #(
	parameter int NUM_IN = `PCIO_NUM_IN,
	parameter int NUM_OUT = `PCIO_NUM_OUT,
	parameter int DEBOUNCE_CYC = `PCIO_DEBOUNCE_CYC
) (
	// Clock and reset
	input wire logic clk,
	input wire logic arst_n,
	// Digital input pins
	input wire logic [NUM_IN-1:0] in_pins,
	// Digital output pins
	output logic [NUM_OUT-1:0] out_pins,
	// Map configuration write port
	input wire logic cfg_in_we,
	input wire logic [3:0] cfg_in_idx,
	input wire pcio_pkg::pcio_fn_t cfg_in_fn,
	input wire logic cfg_out_we,
	input wire logic [3:0] cfg_out_idx,
	input wire pcio_pkg::pcio_fn_t cfg_out_fn,
	// Measurement core hooks
	input wire logic ready,
	input wire logic stop_reached,
	input wire logic contact_seen,
	input wire logic piece_pass,
	input wire logic piece_special,
	input wire logic encoder_index,
	input wire logic alert_req,
	input wire logic test_req,
	input wire logic reset_key,
	// Status to the measurement core
	output logic acq_active,
	output logic acq_abort,
	output logic position_zero,
	output logic supervision_en,
	output logic locked,
	output logic [7:0] recipe_num,
	output logic [7:0] step_num,
	output pcio_pkg::pcio_state_e state
);
	import pcio_pkg::*;

	// ==========================================================
	// Input conditioning
	logic [NUM_IN-1:0] in_lvl;
	genvar gi;
	generate
		for (gi = 0; gi < NUM_IN; gi++) begin : g_in
			pcio_debounce #(.CYCLES(DEBOUNCE_CYC)) u_db (
				.clk(clk),
				.arst_n(arst_n),
				.pin(in_pins[gi]),
				.level(in_lvl[gi])
			);
		end
	endgenerate

	// ==========================================================
	// Map storage
	pcio_fn_t in_map_q [NUM_IN];
	pcio_fn_t out_map_q [NUM_OUT];

	function automatic pcio_fn_t in_default(input int i);
		case (i)
			0: in_default = `PCIO_DEF_IN0;
			1: in_default = `PCIO_DEF_IN1;
			2: in_default = `PCIO_DEF_IN2;
			3: in_default = `PCIO_DEF_IN3;
			4: in_default = `PCIO_DEF_IN4;
			5: in_default = `PCIO_DEF_IN5;
			6: in_default = `PCIO_DEF_IN6;
			7: in_default = `PCIO_DEF_IN7;
			default: in_default = PCIO_IN_NONE;
		endcase
	endfunction

	function automatic pcio_fn_t out_default(input int i);
		case (i)
			0: out_default = `PCIO_DEF_OUT0;
			1: out_default = `PCIO_DEF_OUT1;
			2: out_default = `PCIO_DEF_OUT2;
			3: out_default = `PCIO_DEF_OUT3;
			4: out_default = `PCIO_DEF_OUT4;
			7: out_default = `PCIO_DEF_OUT7;
			default: out_default = PCIO_OUT_NONE;
		endcase
	endfunction

	generate
		for (gi = 0; gi < NUM_IN; gi++) begin : g_imap
			always_ff @(posedge clk or negedge arst_n) begin
				if (!arst_n) begin
					in_map_q[gi] <= in_default(gi);
				end else if (gi == `PCIO_REST_PIN) begin
					in_map_q[gi] <= PCIO_IN_REST;
				end else if (cfg_in_we && cfg_in_idx == 4'(gi)) begin
					// Rest limit only lives on its fixed pin
					in_map_q[gi] <= (cfg_in_fn == PCIO_IN_REST) ? PCIO_IN_NONE
						: cfg_in_fn;
				end
			end
		end
		for (gi = 0; gi < NUM_OUT; gi++) begin : g_omap
			always_ff @(posedge clk or negedge arst_n) begin
				if (!arst_n) begin
					out_map_q[gi] <= out_default(gi);
				end else if (cfg_out_we && cfg_out_idx == 4'(gi)) begin
					out_map_q[gi] <= cfg_out_fn;
				end
			end
		end
	endgenerate

	// ==========================================================
	// Function decode from pins
	logic start_f;
	logic rest_f;
	logic reset_f;
	logic service_f;
	logic permit_ok;
	logic [7:0] recipe_d;
	logic [7:0] step_d;

	always_comb begin
		logic [3:0] rb;
		logic [3:0] sb;
		rb = '0;
		sb = '0;
		start_f = 1'b0;
		rest_f = in_lvl[`PCIO_REST_PIN];
		reset_f = 1'b0;
		service_f = 1'b0;
		permit_ok = 1'b1;
		recipe_d = '0;
		step_d = '0;
		// Several pins may share one function; they combine here
		for (int i = 0; i < NUM_IN; i++) begin
			case (in_map_q[i])
				PCIO_IN_START, PCIO_IN_PULSE_L, PCIO_IN_PULSE_R:
					start_f = start_f | in_lvl[i];
				PCIO_IN_RESET: reset_f = reset_f | in_lvl[i];
				PCIO_IN_SERVICE: service_f = service_f | in_lvl[i];
				PCIO_IN_PERMIT: permit_ok = permit_ok & in_lvl[i];
				PCIO_IN_RECIPE_BIT: begin
					// Lowest pin is bit 0; pins past the eighth are ignored
					if (rb < 4'h8) begin
						recipe_d[rb[2:0]] = in_lvl[i];
					end
					rb = rb + 4'h1;
				end
				PCIO_IN_STEP_BIT: begin
					if (sb < 4'h8) begin
						step_d[sb[2:0]] = in_lvl[i];
					end
					sb = sb + 4'h1;
				end
				default: ;
			endcase
		end
	end

	assign supervision_en = !service_f;
	// Index pulse only zeroes position with the cylinder back
	assign position_zero = rest_f & encoder_index;

	// Job changes are ignored while a cycle request is active
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			recipe_num <= '0;
			step_num <= '0;
		end else if (!start_f) begin
			recipe_num <= recipe_d;
			step_num <= step_d;
		end
	end

	// ==========================================================
	// Cycle sequencer
	logic consent_q;
	logic pass_q;
	logic fail1_q;
	logic fail2_q;
	logic verdict_q;
	logic special_q;
	logic lock_clr;

	// In service mode the reject lockout is not enforced
	assign lock_clr = reset_f | reset_key | service_f;

	// Cylinder must be seen off the rest switch before a return counts;
	// the filtered rest level lags the pin, so an early stop still sees it high
	logic left_rest_q;
	logic returned;

	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			left_rest_q <= 1'b0;
		end else if (state == PCIO_ST_IDLE) begin
			left_rest_q <= 1'b0;
		end else if (acq_active && !rest_f) begin
			left_rest_q <= 1'b1;
		end
	end

	assign returned = left_rest_q && rest_f;

	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			state <= PCIO_ST_IDLE;
			consent_q <= 1'b0;
			verdict_q <= 1'b0;
			special_q <= 1'b0;
			acq_abort <= 1'b0;
		end else begin
			acq_abort <= 1'b0;
			case (state)
				PCIO_ST_IDLE: begin
					// A cycle never starts away from the rest position
					if (start_f && ready && rest_f && (permit_ok || service_f)) begin
						state <= PCIO_ST_PRESS;
						consent_q <= 1'b1;
					end
				end
				PCIO_ST_PRESS: begin
					if (!start_f) begin
						state <= PCIO_ST_IDLE;
						consent_q <= 1'b0;
						acq_abort <= 1'b1;
					end else if (stop_reached) begin
						consent_q <= 1'b0;
						verdict_q <= piece_pass;
						special_q <= piece_special;
						state <= PCIO_ST_RETURN;
					end
				end
				PCIO_ST_RETURN: begin
					if (!start_f) begin
						state <= PCIO_ST_IDLE;
						acq_abort <= 1'b1;
					end else if (returned) begin
						// A stale filtered rest level is not a return
						state <= PCIO_ST_RESULT;
					end
				end
				PCIO_ST_RESULT: begin
					// Result holds until the request is released at rest; a fail outside service mode goes to lock first
					if (!verdict_q && !service_f) begin
						state <= PCIO_ST_LOCK;
					end else if (!start_f && rest_f) begin
						state <= PCIO_ST_IDLE;
					end
				end
				PCIO_ST_LOCK: begin
					if (lock_clr) begin
						state <= PCIO_ST_IDLE;
					end
				end
				default: state <= PCIO_ST_IDLE;
			endcase
		end
	end

	assign locked = (state == PCIO_ST_LOCK);
	assign acq_active = (state == PCIO_ST_PRESS) || (state == PCIO_ST_RETURN);

	// Result flags set on entry to result, kept through lock, cleared on new press
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			pass_q <= 1'b0;
			fail1_q <= 1'b0;
			fail2_q <= 1'b0;
		end else if (state == PCIO_ST_RETURN && returned && start_f) begin
			pass_q <= verdict_q;
			fail1_q <= !verdict_q && !special_q;
			fail2_q <= !verdict_q && special_q;
		end else if (state == PCIO_ST_PRESS || (state == PCIO_ST_IDLE && !locked)) begin
			pass_q <= (state == PCIO_ST_IDLE) ? pass_q : 1'b0;
			fail1_q <= (state == PCIO_ST_IDLE) ? fail1_q : 1'b0;
			fail2_q <= (state == PCIO_ST_IDLE) ? fail2_q : 1'b0;
		end
	end

	logic contact_o;
	assign contact_o = consent_q && contact_seen && !rest_f;

	// ==========================================================
	// Output pins
	generate
		// The n-th pin carrying a bit function shows bit n of its number
		for (gi = 0; gi < NUM_OUT; gi++) begin : g_out
			logic [3:0] idx;
			always_comb begin
				idx = '0;
				for (int j = 0; j < gi; j++) begin
					if (out_map_q[j] == out_map_q[gi]) begin
						idx = idx + 4'h1;
					end
				end
			end
			pcio_out_mux u_mux (
				.clk(clk),
				.arst_n(arst_n),
				.fn(out_map_q[gi]),
				.bit_idx(idx),
				.pass(pass_q),
				.fail1(fail1_q),
				.fail2(fail2_q),
				.consent(consent_q),
				.alert(alert_req),
				.test_trig(test_req),
				.contact(contact_o),
				.recipe(recipe_num),
				.step(step_num),
				.pin(out_pins[gi])
			);
		end
	endgenerate
endmodule

/* verif/pcio_seq_assertions.sv */
// Port-level checks of the press-cycle sequencer
`timescale 1ns/1ps
module pcio_seq_assertions
	import pcio_pkg::*;
#(
	parameter int NUM_OUT = 15
) (
	// Clock and reset
	input wire logic clk,
	input wire logic arst_n,
	// Watched ports
	input wire logic [NUM_OUT-1:0] out_pins,
	input wire logic ready,
	input wire logic stop_reached,
	input wire logic encoder_index,
	input wire logic reset_key,
	input wire logic acq_abort,
	input wire logic acq_active,
	input wire logic position_zero,
	input wire logic locked,
	input wire pcio_pkg::pcio_state_e state
);
	// ==========
	// Cycle steps
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (!arst_n);
	sequence s_enter_press;
		state == PCIO_ST_IDLE ##1 state == PCIO_ST_PRESS;
	endsequence
	sequence s_leave_press;
		state == PCIO_ST_PRESS ##1 state == PCIO_ST_RETURN;
	endsequence
	// Consent is checked on pin 2, which the bench never remaps
	a_press_ready: assert property (s_enter_press |-> $past(ready))
		else $error("press entered without ready");
	a_consent_rise: assert property (s_enter_press |=> out_pins[2])
		else $error("consent late");
	a_consent_src: assert property (out_pins[2] |-> $past(state) == PCIO_ST_PRESS)
		else $error("consent outside press");
	a_stop_return: assert property (s_leave_press |-> $past(stop_reached))
		else $error("return without stop");
	a_consent_drop: assert property (s_leave_press |=> !out_pins[2])
		else $error("consent held after stop");
	a_result_order: assert property ($changed(state) && state == PCIO_ST_RESULT
		|-> $past(state) == PCIO_ST_RETURN)
		else $error("result not after return");
	a_pass_at_rest: assert property ($rose(out_pins[0]) |-> $past(state) == PCIO_ST_RESULT)
		else $error("pass shown before return to rest");
	a_contact_consent: assert property (out_pins[4] |-> out_pins[2])
		else $error("contact without consent");
	a_abort_seen: assert property ($fell(acq_active) && state == PCIO_ST_IDLE
		|-> ##[0:1] acq_abort)
		else $error("abort missing");
	a_abort_pulse: assert property (acq_abort |-> state == PCIO_ST_IDLE ##1 !acq_abort)
		else $error("abort not a pulse");
	a_lock_key: assert property (locked && reset_key |-> ##[1:4] !locked)
		else $error("lock not cleared");
	a_lock_exit: assert property (locked ##1 !locked |-> state == PCIO_ST_IDLE)
		else $error("lock left wrongly");
	a_zero_index: assert property (position_zero |-> encoder_index)
		else $error("zero without index");
endmodule

bind pcio_sequencer pcio_seq_assertions #(.NUM_OUT(NUM_OUT)) u_pcio_chk (
	.clk(clk), .arst_n(arst_n), .out_pins(out_pins), .ready(ready),
	.stop_reached(stop_reached), .encoder_index(encoder_index), .reset_key(reset_key),
	.acq_abort(acq_abort), .acq_active(acq_active), .position_zero(position_zero),
	.locked(locked), .state(state)
);

/* verif/pcio_plc_model.sv */
// Machine-side model: cycle request and cylinder rest switch
`timescale 1ns/1ps
module pcio_plc_model (
	// Clock and reset
	input wire logic clk,
	input wire logic arst_n,
	// Commands and consent
	input wire logic req,
	input wire logic slow,
	input wire logic go,
	// Field wires
	output logic start,
	output logic rest
);
	logic [3:0] cnt_q;
	// ==========
	// Cylinder leaves rest on consent, returns after a travel delay
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			start <= 1'b0;
			rest <= 1'b1;
			cnt_q <= 4'h0;
		end else begin
			start <= req;
			if (go) begin
				rest <= 1'b0;
				cnt_q <= slow ? 4'hc : 4'h2;
			end else if (cnt_q != 4'h0) begin
				cnt_q <= cnt_q - 4'h1;
			end else begin
				rest <= 1'b1;
			end
		end
	end
endmodule

/* verif/test_press_cycle_io_sequencer.sv */
// Self-checking bench of the press-cycle sequencer
`timescale 1ns/1ps
module test_press_cycle_io_sequencer;
	import pcio_pkg::*;
	logic clk = 1'b0;
	logic arst_n = 1'b0;
	logic [14:0] pins_q = 15'h0000;
	logic [14:0] in_pins, out_pins;
	logic cfg_in_we, cfg_out_we, req, slow, plc_start, plc_rest, p, s;
	logic [3:0] cfg_idx;
	pcio_fn_t cfg_fn;
	logic ready, stop_reached, contact_seen, piece_pass, piece_special;
	logic encoder_index, alert_req, test_req, reset_key;
	logic acq_active, acq_abort, position_zero, supervision_en, locked;
	logic [7:0] recipe_num, step_num;
	pcio_state_e state;
	int mismatches = 0;
	int num_checks = 0;
	int aborts = 0;
	int src;

	always #20 clk = ~clk;
	always @(negedge clk) if (acq_abort === 1'b1) aborts++;
	// Pins 0 and 1 belong to the machine model
	assign in_pins = {pins_q[14:2], plc_rest, plc_start};

	pcio_sequencer #(.NUM_IN(15), .NUM_OUT(15), .DEBOUNCE_CYC(2)) u_dut (
		.clk(clk), .arst_n(arst_n), .in_pins(in_pins), .out_pins(out_pins),
		.cfg_in_we(cfg_in_we), .cfg_in_idx(cfg_idx), .cfg_in_fn(cfg_fn),
		.cfg_out_we(cfg_out_we), .cfg_out_idx(cfg_idx), .cfg_out_fn(cfg_fn),
		.ready(ready), .stop_reached(stop_reached), .contact_seen(contact_seen),
		.piece_pass(piece_pass), .piece_special(piece_special),
		.encoder_index(encoder_index), .alert_req(alert_req), .test_req(test_req),
		.reset_key(reset_key), .acq_active(acq_active), .acq_abort(acq_abort),
		.position_zero(position_zero), .supervision_en(supervision_en), .locked(locked),
		.recipe_num(recipe_num), .step_num(step_num), .state(state));
	pcio_plc_model u_plc (.clk(clk), .arst_n(arst_n), .req(req), .slow(slow),
		.go(out_pins[2]), .start(plc_start), .rest(plc_rest));

	// ==========
	// Helpers
	task summarize();
		$display("checks %0d mismatches %0d", num_checks, mismatches);
		if (mismatches == 0 && num_checks > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask
	task chk(input string n, input logic [14:0] e, input logic [14:0] g);
		num_checks++;
		if (g !== e) begin
			$display("ERROR %s expected %h seen %h", n, e, g);
			mismatches++;
		end
	endtask
	task chk1(input string n, input logic e, input logic g);
		chk(n, {14'h0000, e}, {14'h0000, g});
	endtask
	task wait_st(input pcio_state_e w);
		for (int i = 0; i < 200 && state !== w; i++) @(negedge clk);
		chk("state", 15'(w), 15'(state));
		if (state !== w) summarize();
	endtask
	task cfg(input logic o, input logic [3:0] i, input pcio_fn_t f);
		@(negedge clk);
		cfg_in_we = !o;
		cfg_out_we = o;
		cfg_idx = i;
		cfg_fn = f;
		@(negedge clk);
		cfg_in_we = 1'b0;
		cfg_out_we = 1'b0;
	endtask
	// Result pins as {special fail, normal fail, pass}
	function automatic logic [2:0] exp_res(input logic pp, input logic ss);
		return pp ? 3'b001 : (ss ? 3'b100 : 3'b010);
	endfunction
	task run_cycle(input int k, input logic pp, input logic ss);
		piece_pass = pp;
		piece_special = ss;
		contact_seen = 1'b1;
		if (k == 0) req = 1'b1; else pins_q[k] = 1'b1;
		wait_st(PCIO_ST_PRESS);
		@(negedge clk);
		chk1("consent on", 1'b1, out_pins[2]);
		chk1("contact at rest", 1'b0, out_pins[4]);
		if (k == 0) begin
			// Let the cylinder leave rest before the stop
			repeat (8) @(negedge clk);
			chk1("contact", 1'b1, out_pins[4]);
		end
		stop_reached = 1'b1;
		wait_st(PCIO_ST_RETURN);
		stop_reached = 1'b0;
		contact_seen = 1'b0;
		repeat (2) @(negedge clk);
		chk1("consent off", 1'b0, out_pins[2]);
		chk("early result", 15'h0000, 15'({out_pins[7], out_pins[1:0]}));
		wait_st(PCIO_ST_RESULT);
		@(negedge clk);
		chk("result", 15'(exp_res(pp, ss)), 15'({out_pins[7], out_pins[1:0]}));
		if (k == 0) req = 1'b0; else pins_q[k] = 1'b0;
		wait_st(pp ? PCIO_ST_IDLE : PCIO_ST_LOCK);
	endtask

	// ==========
	// Main sequence
	initial begin
		{cfg_in_we, cfg_out_we, req, slow, stop_reached, contact_seen} = 6'h00;
		{piece_pass, piece_special, encoder_index, alert_req, test_req, reset_key} = 6'h00;
		{cfg_idx, cfg_fn} = 9'h000;
		ready = 1'b1;
		void'($urandom(32'h16eb));
		repeat (4) @(negedge clk);
		arst_n = 1'b1;
		chk("outputs", 15'h0000, out_pins);
		chk1("supervision", 1'b1, supervision_en);
		repeat (8) @(negedge clk);
		encoder_index = 1'b1;
		@(negedge clk);
		chk1("zero", 1'b1, position_zero);
		encoder_index = 1'b0;
		$display("test defaults done");
		cfg(1'b0, 4'h9, PCIO_IN_PERMIT);
		ready = 1'b0;
		req = 1'b1;
		repeat (20) @(negedge clk);
		chk("no ready", 15'(PCIO_ST_IDLE), 15'(state));
		ready = 1'b1;
		repeat (20) @(negedge clk);
		chk("no permit", 15'(PCIO_ST_IDLE), 15'(state));
		pins_q[9] = 1'b1;
		run_cycle(0, 1'b1, 1'b0);
		req = 1'b1;
		wait_st(PCIO_ST_PRESS);
		req = 1'b0;
		wait_st(PCIO_ST_IDLE);
		@(negedge clk);
		chk("aborts", 15'h0001, 15'(aborts));
		$display("test request done");
		cfg(1'b0, 4'h8, PCIO_IN_RESET);
		for (int k = 0; k < 9; k++) begin
			{p, s, slow} = 3'($urandom);
			src = (k % 3 == 0) ? 0 : 5 + k % 3;
			run_cycle(src, p, s);
			if (!p) begin
				req = 1'b1;
				repeat (20) @(negedge clk);
				chk("locked", 15'(PCIO_ST_LOCK), 15'(state));
				req = 1'b0;
				repeat (8) @(negedge clk);
				if (k[0]) pins_q[8] = 1'b1; else reset_key = 1'b1;
				wait_st(PCIO_ST_IDLE);
				pins_q[8] = 1'b0;
				reset_key = 1'b0;
			end
		end
		$display("test cycles done");
		for (int i = 10; i < 15; i++)
			cfg(1'b0, 4'(i), i < 13 ? PCIO_IN_RECIPE_BIT : PCIO_IN_STEP_BIT);
		for (int i = 9; i < 14; i++)
			cfg(1'b1, 4'(i), i < 12 ? PCIO_OUT_RECIPE_BIT : PCIO_OUT_STEP_BIT);
		for (int k = 0; k < 6; k++) begin
			pins_q[14:10] = k == 0 ? 5'h1f : 5'($urandom);
			repeat (8) @(negedge clk);
			chk("recipe", 15'(pins_q[12:10]), 15'(recipe_num));
			chk("step", 15'(pins_q[14:13]), 15'(step_num));
			chk("bit outs", 15'(pins_q[14:10]), 15'(out_pins[14:9]));
		end
		$display("test select done");
		cfg(1'b1, 4'h5, PCIO_OUT_TEST_TRIG);
		{alert_req, test_req} = 2'b11;
		repeat (2) @(negedge clk);
		chk("alert trig", 15'h0028, out_pins & 15'h0028);
		{alert_req, test_req} = 2'b00;
		repeat (2) @(negedge clk);
		chk("alert trig", 15'h0000, out_pins & 15'h0028);
		$display("test signals done");
		pins_q[5] = 1'b1;
		pins_q[9] = 1'b0;
		repeat (8) @(negedge clk);
		chk1("supervision", 1'b0, supervision_en);
		run_cycle(0, 1'b1, 1'b0);
		$display("test service done");
		summarize();
	end
endmodule
